// *** tuc_map.svh ***
/*
 * register offsets, field positions, reset values and counts of the
 * translation unit feature and function-control bank.
 * assumes inclusion by bare name from design files and the bench.
 */
`ifndef TUC_MAP_SVH
`define TUC_MAP_SVH

// ----------------------------------------------------------------
// offsets (byte addresses, one aligned word each)
// ----------------------------------------------------------------
`define TUC_ADR_W 16
`define TUC_OFS_FEAT_LO 16'h0008
`define TUC_OFS_FEAT_HI 16'h000C
`define TUC_OFS_FCTL 16'h0020
`define TUC_OFS_STAT 16'h0040

// ----------------------------------------------------------------
// feature register fields
// ----------------------------------------------------------------
`define TUC_FEAT_CIL_HI 4
`define TUC_FEAT_CWID_HI_MSB 3
`define TUC_FEAT_HCC_MSB 31
`define TUC_FEAT_HCC_LSB 24
`define TUC_FEAT_PTA 19
`define TUC_FEAT_SYSTEM_ERROR_SUPPORT 18
`define TUC_FEAT_DWID_MSB 17
`define TUC_FEAT_DWID_LSB 13
`define TUC_FEAT_IWID_MSB 12
`define TUC_FEAT_IWID_LSB 8
`define TUC_FEAT_ESZ_MSB 7
`define TUC_FEAT_ESZ_LSB 4
`define TUC_FEAT_CCT 2
`define TUC_FEAT_VIRT 1
`define TUC_FEAT_PHYS 0
`define TUC_ENTRY_SIZE 4'h3
`define TUC_HCC_VAL 8'h00
`define TUC_COL_WIDTH 16
`define TUC_DEV_WIDTH 20
`define TUC_INT_WIDTH 16

// ----------------------------------------------------------------
// function control fields
// ----------------------------------------------------------------
`define TUC_FC_DCC 31
`define TUC_FC_PWE 30
`define TUC_FC_IEC 18
`define TUC_FC_IDC 17
`define TUC_FC_ICC 16
`define TUC_FC_ROUTE 11
`define TUC_FC_QD 9
`define TUC_FC_AEE 8
`define TUC_FC_CGO_MSB 7
`define TUC_FC_CGO_LSB 4
`define TUC_FC_CEE 3
`define TUC_FC_UEE 2
`define TUC_FC_LTE 1
`define TUC_FC_SIP 0
`define TUC_FC_RW_MASK 32'hC0000BFE
`define TUC_FC_QUIET_MASK 32'h8000000E
`define TUC_FC_RESET 32'h00000000

// ----------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------
`define TUC_ST_QUIET 0
`define TUC_ST_SCRUB 1
`define TUC_ST_LPREQ 2

// ----------------------------------------------------------------
// scrub sweep
// ----------------------------------------------------------------
`define TUC_SCRUB_AW 8
`define TUC_SCRUB_LAST 8'hFF

`endif

// *** tuc_pkg.sv ***
/*
 * types shared by the translation unit register bank.
 * assumes nothing of its surroundings.
 */
package tuc_pkg;

	typedef enum logic [4:0] {
		TUC_SEL_NONE = 5'h01,
		TUC_SEL_FLO = 5'h02,
		TUC_SEL_FHI = 5'h04,
		TUC_SEL_FCTL = 5'h08,
		TUC_SEL_STAT = 5'h10
	} tuc_sel_t;

	typedef enum logic [1:0] {
		TUC_SCRUB_IDLE = 2'h1,
		TUC_SCRUB_RUN = 2'h2
	} tuc_scrub_st_t;

endpackage

// *** tuc_wb_port.sv ***
/*
 * classic wishbone slave front end: decode and registered acknowledge.
 * assumes a master that holds its request until it sees ack.
 */
`timescale 1ns/10ps
`include "tuc_map.svh"

module tuc_wb_port (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [15:0] wb_adr_i,
	output logic wb_ack_o,
	output logic req_o,
	output logic wr_o,
	output tuc_pkg::tuc_sel_t sel_o
);
	import tuc_pkg::*;

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	function automatic tuc_sel_t decode(input logic [15:0] adr);
		tuc_sel_t s;
		s = TUC_SEL_NONE;
		if (adr == `TUC_OFS_FEAT_LO) begin
			s = TUC_SEL_FLO;
		end else if (adr == `TUC_OFS_FEAT_HI) begin
			s = TUC_SEL_FHI;
		end else if (adr == `TUC_OFS_FCTL) begin
			s = TUC_SEL_FCTL;
		end else if (adr == `TUC_OFS_STAT) begin
			s = TUC_SEL_STAT;
		end
		return s;
	endfunction

	logic ack;
	wire logic next_ack;

	// one wait state: data is loaded on the request edge, ack follows
	assign req_o = wb_cyc_i & wb_stb_i & ~ack;
	assign next_ack = req_o;
	assign wr_o = ack & wb_cyc_i & wb_stb_i & wb_we_i;
	assign sel_o = decode({wb_adr_i[15:2], 2'b00});
	assign wb_ack_o = ack;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack <= 1'b0;
		end else begin
			ack <= next_ack;
		end
	end
endmodule

// *** tuc_scrub.sv ***
/*
 * ram scrub sequencer: sweeps every word address once, then stops.
 * assumes the rams take one write per cycle at scrub_addr_o.
 */
`timescale 1ns/10ps
`include "tuc_map.svh"

module tuc_scrub (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic start_i,
	input wire logic abort_i,
	output logic busy_o,
	output logic done_o,
	output logic [7:0] addr_o,
	output logic we_o
);
	import tuc_pkg::*;

	tuc_scrub_st_t state;
	tuc_scrub_st_t next_state;
	logic [7:0] addr;
	logic [7:0] next_addr;
	wire logic last;

	assign last = (addr == `TUC_SCRUB_LAST);

	// start beats abort and completion, so a fresh request is never lost
	always_comb begin
		next_state = state;
		next_addr = addr;
		case (state)
			TUC_SCRUB_IDLE: begin
				if (start_i) begin
					next_state = TUC_SCRUB_RUN;
					next_addr = 8'h00;
				end
			end
			TUC_SCRUB_RUN: begin
				if (start_i) begin
					next_addr = 8'h00;
				end else if (abort_i || last) begin
					next_state = TUC_SCRUB_IDLE;
				end else begin
					next_addr = addr + 8'h01;
				end
			end
			default: begin
				next_state = TUC_SCRUB_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= TUC_SCRUB_IDLE;
			addr <= 8'h00;
			done_o <= 1'b0;
		end else begin
			state <= next_state;
			addr <= next_addr;
			done_o <= (state == TUC_SCRUB_RUN) & last & ~start_i & ~abort_i;
		end
	end

	assign busy_o = (state == TUC_SCRUB_RUN);
	assign we_o = (state == TUC_SCRUB_RUN);
	assign addr_o = addr;
endmodule

// *** tuc_regs.sv ***
/*
 * translation unit feature and function-control register bank.
 * assumes a classic wishbone master, quiescent status and error events
 * from logic on clk_i, and a low-power request pin from outside.
 */
// Notes on behaviour
// - collection limit bit reads one
// - collection width field is width minus one
// - hardware collection count and cumulative tables zero
// - target address and system error bits zero
// - device width field is width minus one
// - interrupt width field is width minus one
// - table entry size field reads three
// - virtual unsupported, physical message interrupts supported
// - control acts on this instance only
// - some control writes ignored unless quiescent
// - conversion-disable selects direct versus translation attribute
// - power-down bit zero requests quiescent indication
// - invalidate bits pulse on one, zero ignored
// - routing bit sends table reads via distributor
// - deny bit refuses every low-power request
// - enables gate access, command, unmapped error reports
// - latency tracking follows its enable bit
// - override bits disable their clock gates
// - scrub bit starts, aborts, reads busy
// - finished scrub clears its bit
`timescale 1ns/10ps
`include "tuc_map.svh"

module tuc_regs #(
	parameter int COL_WIDTH = `TUC_COL_WIDTH,
	parameter int DEV_WIDTH = `TUC_DEV_WIDTH,
	parameter int INT_WIDTH = `TUC_INT_WIDTH
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [15:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic quiescent_i,
	output logic quiescent_request_o,
	output logic direct_attribute_o,
	output logic invalidate_event_o,
	output logic invalidate_device_o,
	output logic invalidate_collection_o,
	output logic route_via_distributor_o,
	input wire logic lp_request_i,
	output logic lp_deny_o,
	input wire logic access_error_i,
	input wire logic command_error_i,
	input wire logic unmapped_error_i,
	output logic access_error_report_o,
	output logic command_error_report_o,
	output logic unmapped_error_report_o,
	output logic latency_tracking_o,
	output logic [3:0] clock_gate_override_o,
	output logic [7:0] scrub_addr_o,
	output logic scrub_write_o
);
	import tuc_pkg::*;

	// ------------------------------------------------------------
	// build-time feature words
	// ------------------------------------------------------------
	localparam logic [3:0] COL_FIELD = 4'(COL_WIDTH - 1);
	localparam logic [4:0] DEV_FIELD = 5'(DEV_WIDTH - 1);
	localparam logic [4:0] INT_FIELD = 5'(INT_WIDTH - 1);

	wire logic [31:0] feat_lo;
	wire logic [31:0] feat_hi;

	// ------------------------------------------------------------
	// feature high word
	// ------------------------------------------------------------
	// limit flag over collection width, rest zero
	assign feat_hi[31:`TUC_FEAT_CIL_HI + 1] = 27'h0000000;
	assign feat_hi[`TUC_FEAT_CIL_HI] = 1'b1;
	assign feat_hi[`TUC_FEAT_CWID_HI_MSB:0] = COL_FIELD;

	// ------------------------------------------------------------
	// feature low word
	// ------------------------------------------------------------
	assign feat_lo[`TUC_FEAT_HCC_MSB:`TUC_FEAT_HCC_LSB] = `TUC_HCC_VAL;
	assign feat_lo[23:20] = 4'h0;
	assign feat_lo[`TUC_FEAT_PTA] = 1'b0;
	assign feat_lo[`TUC_FEAT_SYSTEM_ERROR_SUPPORT] = 1'b0;
	assign feat_lo[`TUC_FEAT_DWID_MSB:`TUC_FEAT_DWID_LSB] = DEV_FIELD;
	assign feat_lo[`TUC_FEAT_IWID_MSB:`TUC_FEAT_IWID_LSB] = INT_FIELD;
	assign feat_lo[`TUC_FEAT_ESZ_MSB:`TUC_FEAT_ESZ_LSB] = `TUC_ENTRY_SIZE;
	assign feat_lo[3] = 1'b0;
	assign feat_lo[`TUC_FEAT_CCT] = 1'b0;
	assign feat_lo[`TUC_FEAT_VIRT] = 1'b0;
	assign feat_lo[`TUC_FEAT_PHYS] = 1'b1;

	// ------------------------------------------------------------
	// bus front end
	// ------------------------------------------------------------
	wire logic req;
	wire logic wr;
	tuc_sel_t sel;

	tuc_wb_port u_port (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i),
		.wb_ack_o(wb_ack_o),
		.req_o(req),
		.wr_o(wr),
		.sel_o(sel)
	);

	// ------------------------------------------------------------
	// write qualification
	// ------------------------------------------------------------
	wire logic fctl_wr;
	wire logic [31:0] lane_mask;
	wire logic [31:0] quiet_gate;
	wire logic [31:0] upd_mask;
	wire logic [31:0] fctl;
	wire logic [31:0] next_fctl;

	assign fctl_wr = wr & (sel == TUC_SEL_FCTL);

	// ------------------------------------------------------------
	// byte lanes
	// ------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_lane
			assign lane_mask[g*8 +: 8] = {8{wb_sel_i[g]}};
		end
	endgenerate

	// ------------------------------------------------------------
	// write masks
	// ------------------------------------------------------------
	// fields that feed live translation logic only move when idle
	assign quiet_gate = quiescent_i ? 32'hFFFFFFFF
		: ~`TUC_FC_QUIET_MASK;
	// reserved and write-only bits never store
	assign upd_mask = fctl_wr ? (lane_mask & quiet_gate
		& `TUC_FC_RW_MASK) : 32'h00000000;
	assign next_fctl = (fctl & ~upd_mask) | (wb_dat_i & upd_mask);

	// ------------------------------------------------------------
	// function control storage
	// ------------------------------------------------------------
	// one flop byte per lane; lives in this instance, never forwarded
	generate
		for (g = 0; g < 4; g++) begin : g_fctl
			logic [7:0] byte_q;
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					byte_q <= 8'(`TUC_FC_RESET >> (g * 8));
				end else begin
					byte_q <= next_fctl[g*8 +: 8];
				end
			end
			assign fctl[g*8 +: 8] = byte_q;
		end
	endgenerate

	// ------------------------------------------------------------
	// invalidate pulses
	// ------------------------------------------------------------
	wire logic inv_lane;
	wire logic [2:0] next_inv;
	wire logic [2:0] inv;

	// only a pulse leaves; nothing is stored, so these bits read zero
	assign inv_lane = fctl_wr & wb_sel_i[2];
	assign next_inv = inv_lane
		? wb_dat_i[`TUC_FC_IEC:`TUC_FC_ICC] : 3'h0;

	generate
		for (g = 0; g < 3; g++) begin : g_inv
			logic pulse;
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					pulse <= 1'b0;
				end else begin
					pulse <= next_inv[g];
				end
			end
			assign inv[g] = pulse;
		end
	endgenerate

	assign invalidate_event_o = inv[2];
	assign invalidate_device_o = inv[1];
	assign invalidate_collection_o = inv[0];

	// ------------------------------------------------------------
	// scrub control
	// ------------------------------------------------------------
	wire logic sip_wr;
	wire logic scrub_start;
	wire logic scrub_abort;
	wire logic scrub_busy;

	assign sip_wr = fctl_wr & wb_sel_i[0];
	assign scrub_start = sip_wr & wb_dat_i[`TUC_FC_SIP];
	assign scrub_abort = sip_wr & ~wb_dat_i[`TUC_FC_SIP];

	// a start during a sweep restarts it from word zero
	// busy drops by itself at the end of the sweep
	tuc_scrub u_scrub (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.start_i(scrub_start),
		.abort_i(scrub_abort),
		.busy_o(scrub_busy),
		.done_o(),
		.addr_o(scrub_addr_o),
		.we_o(scrub_write_o)
	);

	// ------------------------------------------------------------
	// pin synchroniser
	// ------------------------------------------------------------
	// only the second flop reads the first
	logic lp_meta;
	logic lp_sync;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lp_meta <= 1'b0;
			lp_sync <= 1'b0;
		end else begin
			lp_meta <= lp_request_i;
			lp_sync <= lp_meta;
		end
	end

	// ------------------------------------------------------------
	// low-power deny
	// ------------------------------------------------------------
	wire logic next_deny;

	// the deny follows the synchronised request, never the raw pin
	assign next_deny = lp_sync & fctl[`TUC_FC_QD];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lp_deny_o <= 1'b0;
		end else begin
			lp_deny_o <= next_deny;
		end
	end

	// ------------------------------------------------------------
	// error reports
	// ------------------------------------------------------------
	wire logic [2:0] err_in;
	wire logic [2:0] err_en;
	wire logic [2:0] next_rep;
	wire logic [2:0] rep;

	// events are not held: a report costs one cycle of latency
	assign err_in = {access_error_i, command_error_i, unmapped_error_i};
	assign err_en = {fctl[`TUC_FC_AEE], fctl[`TUC_FC_CEE],
		fctl[`TUC_FC_UEE]};
	assign next_rep = err_in & err_en;

	generate
		for (g = 0; g < 3; g++) begin : g_rep
			logic flag;
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					flag <= 1'b0;
				end else begin
					flag <= next_rep[g];
				end
			end
			assign rep[g] = flag;
		end
	endgenerate

	assign access_error_report_o = rep[2];
	assign command_error_report_o = rep[1];
	assign unmapped_error_report_o = rep[0];

	// ------------------------------------------------------------
	// level outputs
	// ------------------------------------------------------------
	assign direct_attribute_o = fctl[`TUC_FC_DCC];
	assign quiescent_request_o = ~fctl[`TUC_FC_PWE];
	assign route_via_distributor_o = fctl[`TUC_FC_ROUTE];
	assign latency_tracking_o = fctl[`TUC_FC_LTE];
	// with no gates fitted, software must keep these set
	assign clock_gate_override_o =
		fctl[`TUC_FC_CGO_MSB:`TUC_FC_CGO_LSB];

	// ------------------------------------------------------------
	// read data
	// ------------------------------------------------------------
	wire logic [31:0] fctl_rd;
	wire logic [31:0] stat_rd;
	wire logic [2:0] stat_bits;
	logic [31:0] rd_mux;
	wire logic [31:0] next_rdat;

	// write-only invalidate bits read zero; bit 0 shows the sweep
	assign fctl_rd = (fctl & `TUC_FC_RW_MASK)
		| {31'h00000000, scrub_busy};
	assign stat_bits = {lp_sync, scrub_busy, quiescent_i};
	assign stat_rd = {29'h00000000, stat_bits};

	// ------------------------------------------------------------
	// read mux
	// ------------------------------------------------------------
	always_comb begin
		case (sel)
			TUC_SEL_FLO: rd_mux = feat_lo;
			TUC_SEL_FHI: rd_mux = feat_hi;
			TUC_SEL_FCTL: rd_mux = fctl_rd;
			TUC_SEL_STAT: rd_mux = stat_rd;
			default: rd_mux = 32'h00000000;
		endcase
	end

	// loaded on the request edge, stable while ack stands
	assign next_rdat = req ? rd_mux : wb_dat_o;

	// ------------------------------------------------------------
	// read data register
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_dat_o <= next_rdat;
		end
	end
endmodule

// *** tuc_regs_props.sv ***
/*
 * port checker for the feature and function-control register bank.
 * assumes it is bound onto tuc_regs, one clock, sync reset high.
 */
`timescale 1ns/10ps

module tuc_regs_props #(
	parameter int COL_WIDTH = 16,
	parameter int DEV_WIDTH = 20,
	parameter int INT_WIDTH = 16
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [15:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic quiescent_i,
	input wire logic quiescent_request_o,
	input wire logic direct_attribute_o,
	input wire logic invalidate_event_o,
	input wire logic route_via_distributor_o,
	input wire logic command_error_i,
	input wire logic command_error_report_o,
	input wire logic [7:0] scrub_addr_o,
	input wire logic scrub_write_o
);
	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	localparam logic [31:0] FLO = (32'(DEV_WIDTH - 1) << 13)
		| (32'(INT_WIDTH - 1) << 8) | 32'h00000031;
	localparam logic [31:0] FHI = 32'h00000010 | 32'(COL_WIDTH - 1);
	wire logic [13:0] wa;
	wire logic req;
	wire logic rd;
	wire logic mapped;
	wire logic fc_wr;
	wire logic scrub_go;
	assign wa = wb_adr_i[15:2];
	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign rd = req && !wb_we_i;
	assign mapped = wa == 14'h2 || wa == 14'h3 || wa == 14'h8 || wa == 14'h10;
	// write takes effect at the ack edge, request still held there
	assign fc_wr = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wa == 14'h8;
	// a start while sweeping restarts from word zero
	assign scrub_go = fc_wr && wb_sel_i[0] && wb_dat_i[0];

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	AST_FEAT_LO: assert property (
		rd && wa == 14'h2 |=> wb_ack_o && wb_dat_o == FLO)
		else $error("feature low word wrong");
	AST_FEAT_HI: assert property (
		rd && wa == 14'h3 |=> wb_ack_o && wb_dat_o == FHI)
		else $error("feature high word wrong");
	AST_UNMAPPED: assert property (
		rd && !mapped |=> wb_ack_o && wb_dat_o == 32'h00000000)
		else $error("unmapped read not zero");
	AST_DIRECT: assert property (
		fc_wr && wb_sel_i[3] && quiescent_i
		|=> direct_attribute_o == $past(wb_dat_i[31]))
		else $error("direct attribute not written");
	AST_BUSY_HOLD: assert property (
		fc_wr && wb_sel_i[3] && !quiescent_i |=> $stable(direct_attribute_o))
		else $error("gated bit written while busy");
	AST_PWR_REQ: assert property (
		fc_wr && wb_sel_i[3] |=> quiescent_request_o == !$past(wb_dat_i[30]))
		else $error("quiescent request wrong");
	AST_ROUTE: assert property (
		fc_wr && wb_sel_i[1]
		|=> route_via_distributor_o == $past(wb_dat_i[11]))
		else $error("routing bit wrong");
	AST_INV_PULSE: assert property (
		fc_wr && wb_sel_i[2]
		|=> invalidate_event_o == $past(wb_dat_i[18]) ##1 !invalidate_event_o)
		else $error("event invalidate pulse wrong");
	AST_ERR_GATE: assert property (
		!command_error_i |=> !command_error_report_o)
		else $error("command error reported without cause");
	AST_SCRUB_START: assert property (
		fc_wr && wb_sel_i[0] && wb_dat_i[0] |-> ##[1:3] scrub_write_o)
		else $error("scrub did not start");
	AST_SCRUB_STEP: assert property (
		scrub_write_o && $past(scrub_write_o) && !$past(scrub_go)
		|-> scrub_addr_o == $past(scrub_addr_o) + 8'h01)
		else $error("scrub address skipped");

	cover property (fc_wr && !quiescent_i);
	cover property (scrub_write_o ##1 !scrub_write_o);
	cover property (command_error_report_o);
endmodule

bind tuc_regs tuc_regs_props #(.COL_WIDTH(COL_WIDTH),
	.DEV_WIDTH(DEV_WIDTH), .INT_WIDTH(INT_WIDTH)) i_props (
	.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .quiescent_i(quiescent_i),
	.quiescent_request_o(quiescent_request_o),
	.direct_attribute_o(direct_attribute_o),
	.invalidate_event_o(invalidate_event_o),
	.route_via_distributor_o(route_via_distributor_o),
	.command_error_i(command_error_i),
	.command_error_report_o(command_error_report_o),
	.scrub_addr_o(scrub_addr_o), .scrub_write_o(scrub_write_o));

// *** tuc_tb.sv ***
/*
 * self-checking bench for the register bank, wishbone master tasks.
 * assumes tuc_pkg and the bound checker are compiled alongside.
 */
`timescale 1ns/10ps
`include "tuc_map.svh"

module testbench;
	import tuc_pkg::*;
	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	localparam int CW = 12;
	localparam int DW = 18;
	localparam int IW = 14;
	localparam logic [31:0] FLO = (32'(DW - 1) << 13) | (32'(IW - 1) << 8)
		| 32'h00000031;
	localparam logic [31:0] FHI = 32'h00000010 | 32'(CW - 1);
	localparam logic [15:0] FC = `TUC_OFS_FCTL;
	logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
	logic [15:0] adr = 0;
	logic [3:0] sel = 0;
	logic [31:0] wdat = 0, rdat, fc = 0;
	logic ack, quiet = 1, lp = 0, qreq, dattr, route, deny, lat, swr;
	logic [2:0] err = 0, inv, rep;
	logic [3:0] clock_gate_override;
	logic [7:0] saddr;
	int mismatches = 0, checks = 0;
	logic [31:0] expq[$];

	tuc_regs #(.COL_WIDTH(CW), .DEV_WIDTH(DW), .INT_WIDTH(IW)) i_dut (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .quiescent_i(quiet),
		.quiescent_request_o(qreq), .direct_attribute_o(dattr),
		.invalidate_event_o(inv[2]), .invalidate_device_o(inv[1]),
		.invalidate_collection_o(inv[0]), .route_via_distributor_o(route),
		.lp_request_i(lp), .lp_deny_o(deny), .access_error_i(err[2]),
		.command_error_i(err[1]), .unmapped_error_i(err[0]),
		.access_error_report_o(rep[2]), .command_error_report_o(rep[1]),
		.unmapped_error_report_o(rep[0]), .latency_tracking_o(lat),
		.clock_gate_override_o(clock_gate_override), .scrub_addr_o(saddr),
		.scrub_write_o(swr));

	initial begin
		forever #12.5 clk_i = ~clk_i;
	end

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic ck(string n, logic [31:0] e, logic [31:0] g);
		checks++;
		if (g !== e) begin
			mismatches++;
			$display("FAIL %s exp %h got %h", n, e, g);
		end
	endtask

	task complete_run;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// one classic cycle; reads leave their expectation for the monitor
	task automatic wb(logic w, logic [15:0] a, logic [3:0] s,
		logic [31:0] d, logic [31:0] e);
		int n;
		if (!w)
			expq.push_back(e);
		@(posedge clk_i);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		sel <= s;
		wdat <= d;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (n >= 20) begin
			mismatches++;
			complete_run;
		end
		cyc <= 0;
		stb <= 0;
		we <= 0;
	endtask

	task automatic lv;
		ck("qreq", 32'(!fc[30]), 32'(qreq));
		ck("dattr", 32'(fc[31]), 32'(dattr));
		ck("route", 32'(fc[11]), 32'(route));
		ck("lat", 32'(fc[1]), 32'(lat));
		ck("cgo", 32'(fc[7:4]), 32'(clock_gate_override));
	endtask

	// control write with lane and quiescence gating in the model
	task automatic wfc(logic q, logic [3:0] s, logic [31:0] d);
		logic [31:0] m;
		@(posedge clk_i);
		quiet <= q;
		m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}} & `TUC_FC_RW_MASK;
		if (!q)
			m = m & ~`TUC_FC_QUIET_MASK;
		fc = (fc & ~m) | (d & m);
		wb(1, FC, s, d, 0);
		#1;
		ck("inv", 32'(d[18:16] & {3{s[2]}}), 32'(inv));
		lv;
	endtask

	// read data is compared only when an ack shows up
	always @(posedge clk_i) begin
		if (ack === 1'b1 && !we)
			ck("rdata", expq.size() ? expq.pop_front() : 32'hDEAD, rdat);
	end

	// ------------------------------------------------------------
	// sequence
	// ------------------------------------------------------------
	initial begin
		logic [3:0] s;
		logic [2:0] e;
		logic l;
		int n;
		void'($urandom(32'h80B9));
		repeat (8) @(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
		#1;
		lv;
		ck("inv", 0, 32'(inv));
		wb(0, FC, 4'hF, 0, 0);
		$display("end reset");
		wb(0, `TUC_OFS_FEAT_LO, 4'hF, 0, FLO);
		wb(0, `TUC_OFS_FEAT_HI, 4'hF, 0, FHI);
		wb(1, `TUC_OFS_FEAT_LO, 4'hF, 32'hFFFFFFFF, 0);
		wb(0, `TUC_OFS_FEAT_LO, 4'hF, 0, FLO);
		wb(1, 16'h0010, 4'hF, $urandom, 0);
		wb(0, 16'h0010, 4'hF, 0, 0);
		$display("end features");
		for (int i = 0; i < 12; i++) begin
			s = 4'($urandom);
			e = 3'($urandom);
			l = 1'($urandom);
			wfc(i[0], s, $urandom & 32'hFFFFFFFE);
			@(posedge clk_i);
			err <= e;
			lp <= l;
			@(posedge clk_i);
			#1;
			ck("rep", 32'(e & {fc[8], fc[3], fc[2]}), 32'(rep));
			repeat (3) @(posedge clk_i);
			#1;
			ck("deny", 32'(l & fc[9]), 32'(deny));
			wb(0, FC, 4'hF, 0, fc);
			wb(0, `TUC_OFS_STAT, 4'hF, 0, {29'h0, l, 1'b0, i[0]});
		end
		$display("end control");
		wb(1, FC, 4'hF, fc | 32'h1, 0);
		#1;
		n = 0;
		while (swr !== 1'b0 && n < 400) begin
			@(posedge clk_i);
			#1;
			n++;
		end
		ck("scrub len", 32'(`TUC_SCRUB_LAST) + 32'h1, 32'(n));
		ck("scrub addr", 32'(`TUC_SCRUB_LAST), 32'(saddr));
		wb(0, FC, 4'hF, 0, fc);
		wb(1, FC, 4'hF, fc | 32'h1, 0);
		wb(0, FC, 4'hF, 0, fc | 32'h1);
		wb(1, FC, 4'hF, fc, 0);
		wb(0, FC, 4'hF, 0, fc);
		ck("swr", 0, 32'(swr));
		$display("end scrub");
		@(posedge clk_i);
		rst_i <= 1;
		repeat (2) @(posedge clk_i);
		rst_i <= 0;
		fc = 0;
		@(posedge clk_i);
		#1;
		lv;
		wb(0, FC, 4'hF, 0, 0);
		$display("end second reset");
		complete_run;
	end
endmodule
